// *** bench/host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_model
  import speed_shaper_pkg::*;
(
  // Clock
  input  wire logic                    clk_in,
  // Requests from the sequence
  input  wire logic signed [SPD_W-1:0] cmd_in,
  input  wire logic signed [SPD_W-1:0] act_in,
  input  wire logic                    zero_in,
  input  wire logic [PSEL_W-1:0]       sel_in,
  // Pins toward the drive
  output logic signed [SPD_W-1:0]      ext_out,
  output logic signed [SPD_W-1:0]      act_out,
  output logic                         zero_out,
  output logic [PSEL_W-1:0]            sel_out
);
  // Pins move once per clock, like a sampled controller
  always_ff @(posedge clk_in) begin
    ext_out  <= cmd_in;   // Host passes its command through unchanged, one clock later
    act_out  <= act_in;   // Speed control only, no outer loop
    zero_out <= zero_in;
    sel_out  <= sel_in;
  end
endmodule
`default_nettype wire

// *** bench/speed_command_shaper_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module speed_command_shaper_bench;
  import speed_shaper_pkg::*;
  // Clock, reset and bus
  logic                    clk, rstn, cyc, stb, we, ack, zpin, hold, usep;
  logic [ADR_W-1:0]        adr;
  logic [3:0]              sel;
  logic [DAT_W-1:0]        dw, dr, rd;
  // Host requests and pins
  logic signed [SPD_W-1:0] cmd, act, ext, acts, spd, pos;
  logic                    zero;
  logic [PSEL_W-1:0]       psel, ppin;
  int                      fail_count, tests_run;

  host_model u_host (.clk_in(clk), .cmd_in(cmd), .act_in(act), .zero_in(zero), .sel_in(psel),
                     .ext_out(ext), .act_out(acts), .zero_out(zpin), .sel_out(ppin));
  speed_command_shaper #(.CYC_PER_MS(4), .SLOT_CYC(2)) u_dut (
    .MCLK_IN(clk), .RSTN_IN(rstn), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
    .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dw), .WB_DAT_OUT(dr), .WB_ACK_OUT(ack),
    .ZERO_SPEED_IN(zpin), .SPEED_SEL_IN(ppin), .EXT_SPEED_IN(ext), .ACTUAL_SPEED_IN(acts),
    .SPEED_CMD_OUT(spd), .POS_HOLD_OUT(hold), .POS_CMD_OUT(pos));

  // Free-running 40 MHz clock
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end

  // Verdict and end of run
  task stop_test;
    if (fail_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Compare one value
  task chk(input string nm, input logic [DAT_W-1:0] e, input logic [DAT_W-1:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  // One classic Wishbone cycle, waits for ack under a bound
  task bus(input logic w, input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
    int n;
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we  <= w;
    adr <= a;
    dw  <= d;
    sel <= 4'hf;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    rd = dr;
    cyc <= 0;
    stb <= 0;
    if (n >= 16) begin
      fail_count++;
      stop_test();
    end
  endtask

  // Read and compare
  task rchk(input string nm, input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] e);
    bus(0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  // Write a parameter, then reload
  task cfg(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
    bus(1, a, d);
    bus(1, OFS_CTRL, {30'h0, 1'b1, usep});
  endtask

  // Let the command settle, then compare it
  task ochk(input string nm, input logic [DAT_W-1:0] e, input int n);
    repeat (n) @(posedge clk);
    chk(nm, e, 32'(spd));
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    stop_test();
  end

  // Main sequence
  initial begin
    {rstn, cyc, stb, we, usep, zero} = '0;
    {adr, sel, dw, psel} = '0;
    {cmd, act} = '0;
    repeat (2) @(posedge clk);
    rstn <= 1;
    rchk("lock", OFS_LOCK, 32'h1e);
    rchk("ovspd", OFS_OVSPD, 32'h4e20);
    rchk("zmode", OFS_ZMODE, 32'h0);
    rchk("preset7", OFS_PRESET0 + 8'h1c, 32'h0);
    rchk("unmapped", 8'h40, 32'h0);
    bus(1, OFS_PRESET0 + 8'h0c, 32'h0000fe0c);
    rchk("preset3", OFS_PRESET0 + 8'h0c, 32'hfffffe0c);
    psel <= 3'h3;
    usep = 1;
    bus(1, OFS_CTRL, 32'h1);
    ochk("before reload", 32'h0, 20);
    bus(1, OFS_CTRL, 32'h3);
    ochk("preset", -500, 20);
    cfg(OFS_OVSPD, 32'd300);
    ochk("limited", -300, 20);
    cmd <= 40;
    usep = 0;
    cfg(OFS_ACCEL, 32'd1000);
    repeat (200) @(posedge clk);
    chk("ramping", 32'h1, 32'(spd > -270 && spd < -230));
    ochk("accel end", 40, 1500);
    cfg(OFS_DECEL, 32'd1000);
    cmd <= -40;
    repeat (100) @(posedge clk);
    chk("decelerating", 32'h1, 32'(spd > 5 && spd < 30));
    ochk("decel", -40, 400);
    cfg(OFS_ACCEL, 32'd0);
    cfg(OFS_DECEL, 32'd0);
    act <= -20;
    cmd <= -25;
    for (int m = 0; m < 4; m++) begin
      cfg(OFS_ZMODE, 32'(m));
      zero <= 1;
      ochk("zcmd", (m == 1 || m == 2) ? 0 : -25, 30);
      chk("hold", 32'(m >= 2), 32'(hold));
      chk("poscmd", 32'h0, 32'(pos));
      zero <= 0;
      ochk("zoff", -25, 30);
      chk("unhold", 32'h0, 32'(hold));
    end
    cmd <= -35;
    zero <= 1;
    ochk("m3cmd", -35, 30);
    chk("m3hold", 32'h0, 32'(hold));
    act <= -40;
    cfg(OFS_ZMODE, 32'd2);
    repeat (30) @(posedge clk);
    chk("m2fast", 32'h0, 32'(hold));
    act <= 20;
    repeat (30) @(posedge clk);
    chk("m2fwd", 32'h1, 32'(hold));
    rchk("stat", OFS_STAT, 32'h3);
    zero <= 0;
    cfg(OFS_SCURVE, 32'd1);
    cmd <= 25;
    repeat (14) @(posedge clk);
    chk("scurve mid", 32'h1, 32'(spd > -35 && spd < 25));
    ochk("scurve end", 25, 80);
    stop_test();
  end
endmodule
`default_nettype wire

// *** rtl/scurve_avg.sv ***
`timescale 1ns/1ps
`default_nettype none
module scurve_avg
  import speed_shaper_pkg::*;
#(
  parameter int DEPTH    = SCURVE_DEPTH,       // Power of two
  parameter int SLOT_CYC = 5000                // Cycles per slot per unit
)(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Ramp path
  scurve_if.filt   port
);
  localparam int IW = $clog2(DEPTH);
  localparam int SW = SPD_W + IW;

  logic signed [SPD_W-1:0] hist [DEPTH];       // Sample history
  logic        [IW-1:0]    idx;                // Oldest slot
  logic signed [SW-1:0]    sum;                // Running window sum
  logic        [31:0]      slot_cnt;           // Cycles within slot
  logic        [31:0]      slot_len;           // Slot length in cycles
  logic signed [SPD_W-1:0] smooth;             // Registered output

  assign slot_len    = 32'(port.ts) * 32'(SLOT_CYC);
  assign port.smooth = smooth;

  // Moving average over the S-curve time centres rounding on each corner
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < DEPTH; i++) hist[i] <= '0;
      idx      <= '0;
      sum      <= '0;
      slot_cnt <= '0;
      smooth   <= '0;
    end else if (port.ts == '0) begin           // Bypass, keep window primed
      for (int i = 0; i < DEPTH; i++) hist[i] <= port.raw;
      sum      <= SW'(port.raw) <<< IW;
      slot_cnt <= '0;
      smooth   <= port.raw;
    end else begin
      if (slot_cnt + 32'h1 >= slot_len) begin   // Slot ends, shift in sample
        hist[idx] <= port.raw;
        sum       <= sum - SW'(hist[idx]) + SW'(port.raw);
        idx       <= idx + 1'b1;
        slot_cnt  <= '0;
      end else begin
        slot_cnt  <= slot_cnt + 32'h1;
      end
      smooth <= SPD_W'(sum >>> IW);
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  property p_scurve_bypass;
    (port.ts == '0) |=> (smooth == $past(port.raw));
  endproperty
  a_scurve_bypass: assert property (p_scurve_bypass)
    else $error("S-curve bypass does not follow ramp");

endmodule
`default_nettype wire

// *** rtl/scurve_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface scurve_if;
  import speed_shaper_pkg::*;
  logic signed [SPD_W-1:0] raw;                 // Linear ramp value
  logic        [9:0]       ts;                  // S-curve time, 2 ms units
  logic signed [SPD_W-1:0] smooth;              // Rounded command
  modport main (output raw, output ts, input smooth);
  modport filt (input raw, input ts, output smooth);
endinterface
`default_nettype wire

// *** rtl/speed_command_shaper.sv ***
// Chosen here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module speed_command_shaper
  import speed_shaper_pkg::*;
#(
  parameter int CYC_PER_MS = CLK_HZ / MS_PER_S,  // Cycles per millisecond
  parameter int SLOT_CYC   = (SCURVE_UNIT_MS * (CLK_HZ / MS_PER_S)) / SCURVE_DEPTH
)(
  // Clock and reset
  input  wire logic                    MCLK_IN,
  input  wire logic                    RSTN_IN,
  // Wishbone slave
  input  wire logic                    WB_CYC_IN,
  input  wire logic                    WB_STB_IN,
  input  wire logic                    WB_WE_IN,
  input  wire logic [ADR_W-1:0]        WB_ADR_IN,
  input  wire logic [3:0]              WB_SEL_IN,
  input  wire logic [DAT_W-1:0]        WB_DAT_IN,
  output logic      [DAT_W-1:0]        WB_DAT_OUT,
  output logic                         WB_ACK_OUT,
  // Host pins
  input  wire logic                    ZERO_SPEED_IN,
  input  wire logic [PSEL_W-1:0]       SPEED_SEL_IN,
  // Same-clock speed inputs
  input  wire logic signed [SPD_W-1:0] EXT_SPEED_IN,
  input  wire logic signed [SPD_W-1:0] ACTUAL_SPEED_IN,
  // Drive outputs
  output logic signed [SPD_W-1:0]      SPEED_CMD_OUT,
  output logic                         POS_HOLD_OUT,
  output logic signed [SPD_W-1:0]      POS_CMD_OUT
);

  // Magnitude of a signed speed, valid for the most negative code
  function automatic logic [SPD_W:0] mag(input logic signed [SPD_W-1:0] v);
    logic signed [SPD_W:0] e;
    e = {v[SPD_W-1], v};
    return e[SPD_W] ? (SPD_W+1)'(-e) : (SPD_W+1)'(e);
  endfunction

  // Limit a signed speed to +/- lim
  function automatic logic signed [SPD_W-1:0] limit(input logic signed [SPD_W-1:0] v,
                                                    input logic [SPD_W-1:0] lim);
    logic signed [SPD_W:0] e;
    logic signed [SPD_W:0] l;
    e = {v[SPD_W-1], v};
    l = {1'b0, lim};
    if (e > l) return SPD_W'(l);
    else if (e < -l) return SPD_W'(-l);
    else return v;
  endfunction

  // Byte-lane merge for a 16-bit register
  function automatic logic [SPD_W-1:0] wr16(input logic [SPD_W-1:0] old,
                                            input logic [DAT_W-1:0] dat,
                                            input logic [3:0]       sel);
    return {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction

  // Software-side copies
  logic signed [SPD_W-1:0] sw_preset [NPRE];     // Preset speeds as written
  logic [SPD_W-1:0]        sw_accel;             // Acceleration time
  logic [SPD_W-1:0]        sw_decel;             // Deceleration time
  logic [SPD_W-1:0]        sw_scurve;            // S-curve time
  logic [1:0]              sw_zmode;             // Zero-speed mode
  logic [SPD_W-1:0]        sw_lock;              // Lock level
  logic [SPD_W-1:0]        sw_ovspd;             // Overspeed level
  logic                    use_preset;           // Preset source select
  logic                    reload;               // Reload pulse

  // Working copies
  logic signed [SPD_W-1:0] act_preset [NPRE];    // Presets in use
  logic [SPD_W-1:0]        act_accel;            // Acceleration in use
  logic [SPD_W-1:0]        act_decel;            // Deceleration in use
  logic [SPD_W-1:0]        act_scurve;           // S-curve in use
  logic [1:0]              act_zmode;            // Mode in use
  logic [SPD_W-1:0]        act_lock;             // Lock level in use
  logic [SPD_W-1:0]        act_ovspd;            // Overspeed in use

  // Bus
  logic                    wb_hit;               // New request this cycle
  logic                    wb_wr;                // Write, applied at the ack edge
  logic [DAT_W-1:0]        rd_word;              // Read mux
  logic                    wb_ack;               // Acknowledge flop
  logic [DAT_W-1:0]        wb_dat;               // Read data flop

  // Pin synchroniser
  logic [PSEL_W:0]         pin_meta;             // First stage
  logic [PSEL_W:0]         pin_s2;               // Second stage
  logic [PSEL_W:0]         pin_s3;               // Third stage
  logic [PSEL_W:0]         pin_ok;               // Agreed value
  logic                    zd;                   // Zero-speed input
  logic [PSEL_W-1:0]       psel;                 // Preset index

  // Command path
  logic signed [SPD_W-1:0] sel_cmd;              // Selected, limited command
  logic signed [SPD_W-1:0] target;               // Ramp target
  logic signed [SPD_W-1:0] ramp;                 // Linear ramp
  logic [31:0]             acc;                  // Ramp rate accumulator
  logic [31:0]             acc_next;             // Accumulator plus step
  logic [31:0]             thr_up;               // Cycles per 1000 r/min up
  logic [31:0]             thr_dn;               // Cycles per 1000 r/min down
  lock_state_t             state;                // Hold state
  lock_state_t             next_state;           // Next hold state
  logic                    clamp_on;             // Zero clamp active
  logic signed [SPD_W-1:0] speed_cmd;            // Output flop
  logic                    pos_hold;             // Output flop
  logic signed [SPD_W-1:0] pos_cmd;              // Output flop

  scurve_if sc ();

  assign wb_hit   = WB_CYC_IN && WB_STB_IN && !wb_ack;
  assign wb_wr    = WB_CYC_IN && WB_STB_IN && WB_WE_IN && wb_ack;
  assign zd       = pin_ok[PSEL_W];
  assign psel     = pin_ok[PSEL_W-1:0];
  assign acc_next = acc + RPM_PER_UNIT;
  assign thr_up   = 32'(act_accel) * 32'(CYC_PER_MS);
  assign thr_dn   = 32'(act_decel) * 32'(CYC_PER_MS);
  assign sc.raw   = ramp;
  assign sc.ts    = act_scurve[9:0];

  assign WB_ACK_OUT    = wb_ack;
  assign WB_DAT_OUT    = wb_dat;
  assign SPEED_CMD_OUT = speed_cmd;
  assign POS_HOLD_OUT  = pos_hold;
  assign POS_CMD_OUT   = pos_cmd;

  // Bus acknowledge, one cycle after the request, dropped the next cycle
  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      wb_ack <= 1'b0;
      wb_dat <= '0;
    end else begin
      wb_ack <= wb_hit;
      if (wb_hit && !WB_WE_IN) begin
        wb_dat <= rd_word;
      end
    end
  end

  // Read decode, unmapped reads return zero
  always_comb begin
    rd_word = '0;
    if (WB_ADR_IN < OFS_ACCEL && WB_ADR_IN[1:0] == 2'h0) begin
      rd_word = DAT_W'(sw_preset[WB_ADR_IN[4:2]]);
    end else begin
      case (WB_ADR_IN)
        OFS_ACCEL:  rd_word = DAT_W'(sw_accel);
        OFS_DECEL:  rd_word = DAT_W'(sw_decel);
        OFS_SCURVE: rd_word = DAT_W'(sw_scurve);
        OFS_ZMODE:  rd_word = DAT_W'(sw_zmode);
        OFS_LOCK:   rd_word = DAT_W'(sw_lock);
        OFS_OVSPD:  rd_word = DAT_W'(sw_ovspd);
        OFS_CTRL:   rd_word[CTRL_USE_PRESET] = use_preset;
        OFS_STAT: begin
          rd_word[STAT_HOLD] = pos_hold;
          rd_word[STAT_ZD]   = zd;
          rd_word[STAT_CMD_LSB +: SPD_W] = speed_cmd;
        end
        default:    rd_word = '0;
      endcase
    end
  end

  // Preset registers, one writable copy and one working copy each
  for (genvar i = 0; i < NPRE; i++) begin : g_preset
    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
        sw_preset[i]  <= RST_ZERO;
        act_preset[i] <= RST_ZERO;
      end else begin
        if (wb_wr && WB_ADR_IN == ADR_W'(OFS_PRESET0 + REG_STRIDE * i)) begin
          sw_preset[i] <= wr16(sw_preset[i], WB_DAT_IN, WB_SEL_IN);
        end
        if (reload) begin
          act_preset[i] <= sw_preset[i];
        end
      end
    end
  end

  // Scalar parameter registers
  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      sw_accel   <= RST_ZERO;
      sw_decel   <= RST_ZERO;
      sw_scurve  <= RST_ZERO;
      sw_zmode   <= ZM_OFF;
      sw_lock    <= RST_LOCK;
      sw_ovspd   <= RST_OVSPD;
      use_preset <= 1'b0;
      reload     <= 1'b0;
    end else begin
      reload <= wb_wr && WB_ADR_IN == OFS_CTRL && WB_SEL_IN[0] && WB_DAT_IN[CTRL_RELOAD];
      if (wb_wr) begin
        case (WB_ADR_IN)
          OFS_ACCEL:  sw_accel  <= wr16(sw_accel, WB_DAT_IN, WB_SEL_IN);
          OFS_DECEL:  sw_decel  <= wr16(sw_decel, WB_DAT_IN, WB_SEL_IN);
          OFS_SCURVE: sw_scurve <= wr16(sw_scurve, WB_DAT_IN, WB_SEL_IN);
          OFS_ZMODE:  if (WB_SEL_IN[0]) sw_zmode <= WB_DAT_IN[1:0];
          OFS_LOCK:   sw_lock   <= wr16(sw_lock, WB_DAT_IN, WB_SEL_IN);
          OFS_OVSPD:  sw_ovspd  <= wr16(sw_ovspd, WB_DAT_IN, WB_SEL_IN);
          OFS_CTRL:   if (WB_SEL_IN[0]) use_preset <= WB_DAT_IN[CTRL_USE_PRESET];
          default:    use_preset <= use_preset;
        endcase
      end
    end
  end

  // Working parameters change only on a reload, standing in for power cycling
  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      act_accel  <= RST_ZERO;
      act_decel  <= RST_ZERO;
      act_scurve <= RST_ZERO;
      act_zmode  <= ZM_OFF;
      act_lock   <= RST_LOCK;
      act_ovspd  <= RST_OVSPD;
    end else if (reload) begin
      act_accel  <= sw_accel;
      act_decel  <= sw_decel;
      act_scurve <= sw_scurve;
      act_zmode  <= sw_zmode;
      act_lock   <= sw_lock;
      act_ovspd  <= sw_ovspd;
    end
  end

  // Pin inputs, accepted once the second and third stages agree
  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      pin_meta <= '0;
      pin_s2   <= '0;
      pin_s3   <= '0;
      pin_ok   <= '0;
    end else begin
      pin_meta <= {ZERO_SPEED_IN, SPEED_SEL_IN};
      pin_s2   <= pin_meta;
      pin_s3   <= pin_s2;
      if (pin_s2 == pin_s3) begin
        pin_ok <= pin_s3;
      end
    end
  end

  // Source select and overspeed limit, sign kept as direction
  always_comb begin
    sel_cmd = limit(use_preset ? act_preset[psel] : EXT_SPEED_IN, act_ovspd);
    clamp_on = zd && (act_zmode == ZM_CLAMP || act_zmode == ZM_CLAMP_LOCK);
  end

  // Ramp target, forced to zero while clamped
  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      target <= '0;
    end else begin
      target <= clamp_on ? RST_ZERO : sel_cmd;
    end
  end

  // Linear ramp, one r/min per step, rate set by the working times
  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ramp <= '0;
      acc  <= '0;
    end else if (target > ramp) begin
      if (act_accel == RST_ZERO) begin          // No ramp, jump
        ramp <= target;
        acc  <= '0;
      end else if (acc_next >= thr_up) begin
        ramp <= ramp + RAMP_STEP;
        acc  <= acc_next - thr_up;
      end else begin
        acc  <= acc_next;
      end
    end else if (target < ramp) begin
      if (act_decel == RST_ZERO) begin          // No ramp, jump
        ramp <= target;
        acc  <= '0;
      end else if (acc_next >= thr_dn) begin
        ramp <= ramp - RAMP_STEP;
        acc  <= acc_next - thr_dn;
      end else begin
        acc  <= acc_next;
      end
    end else begin
      acc <= '0;                                 // Settled
    end
  end

  scurve_avg #(
    .DEPTH    (SCURVE_DEPTH),
    .SLOT_CYC (SLOT_CYC)
  ) u_scurve (
    .clk_in  (MCLK_IN),
    .rstn_in (RSTN_IN),
    .port    (sc.filt)
  );

  // Hold decision
  always_comb begin
    next_state = state;
    case (state)
      ST_SPEED: begin
        if (zd && act_zmode == ZM_CLAMP_LOCK &&
            mag(ACTUAL_SPEED_IN) < {1'b0, act_lock}) begin
          next_state = ST_HOLD;
        end else if (zd && act_zmode == ZM_LOCK &&
                     mag(sel_cmd) < {1'b0, act_lock}) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!zd || !(act_zmode == ZM_CLAMP_LOCK || act_zmode == ZM_LOCK)) begin
          next_state = ST_SPEED;
        end
      end
      default: next_state = ST_SPEED;
    endcase
  end

  // Hold state and drive outputs
  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      state     <= ST_SPEED;
      pos_hold  <= 1'b0;
      pos_cmd   <= '0;
      speed_cmd <= '0;
    end else begin
      state     <= next_state;
      pos_hold  <= (next_state == ST_HOLD);
      pos_cmd   <= RST_ZERO;                     // Fixed zero hold target
      speed_cmd <= sc.smooth;
    end
  end

  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RSTN_IN);

  property p_ovspd;
    mag(target) <= {1'b0, $past(act_ovspd)};
  endproperty
  a_ovspd: assert property (p_ovspd)
    else $error("Target exceeds overspeed level");

  property p_accel_bypass;
    (target > ramp && act_accel == RST_ZERO) |=> (ramp == $past(target));
  endproperty
  a_accel_bypass: assert property (p_accel_bypass)
    else $error("Zero acceleration time did not jump");

  property p_accel_step;
    (target > ramp && act_accel != RST_ZERO) |=> (ramp == $past(ramp) || ramp == $past(ramp) + RAMP_STEP);
  endproperty
  a_accel_step: assert property (p_accel_step)
    else $error("Acceleration step too large");

  property p_decel_step;
    (target < ramp && act_decel != RST_ZERO) |=> (ramp == $past(ramp) || ramp == $past(ramp) - RAMP_STEP);
  endproperty
  a_decel_step: assert property (p_decel_step)
    else $error("Deceleration step too large");

  property p_clamp;
    (zd && act_zmode == ZM_CLAMP) |=> (target == RST_ZERO);
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("Zero clamp not applied");

  property p_mode_off;
    (act_zmode == ZM_OFF) |=> !pos_hold;
  endproperty
  a_mode_off: assert property (p_mode_off)
    else $error("Hold while zero-speed mode is off");

  property p_release;
    (pos_hold && !zd) |=> !pos_hold;
  endproperty
  a_release: assert property (p_release)
    else $error("Hold not released on input off");

  property p_lock_actual;
    ($rose(pos_hold) && $past(act_zmode) == ZM_CLAMP_LOCK) |->
      ($past(zd) && $past(mag(ACTUAL_SPEED_IN)) < {1'b0, $past(act_lock)});
  endproperty
  a_lock_actual: assert property (p_lock_actual)
    else $error("Mode 2 hold entered above lock level");

  property p_lock_cmd;
    ($rose(pos_hold) && $past(act_zmode) == ZM_LOCK) |->
      ($past(zd) && $past(mag(sel_cmd)) < {1'b0, $past(act_lock)});
  endproperty
  a_lock_cmd: assert property (p_lock_cmd)
    else $error("Mode 3 hold entered above lock level");

  property p_reload_only;
    ($changed(act_accel) || $changed(act_zmode)) |-> $past(reload);
  endproperty
  a_reload_only: assert property (p_reload_only)
    else $error("Working parameter changed without reload");

endmodule
`default_nettype wire

// *** rtl/speed_shaper_pkg.sv ***
package speed_shaper_pkg;

  // Widths
  localparam int SPD_W  = 16;                    // Speed word width
  localparam int ADR_W  = 8;                     // Byte address width
  localparam int DAT_W  = 32;                    // Bus data width
  localparam int NPRE   = 8;                     // Number of presets
  localparam int PSEL_W = 3;                     // Preset select width

  // Register byte offsets
  localparam logic [ADR_W-1:0] OFS_PRESET0 = 8'h00;
  localparam logic [ADR_W-1:0] OFS_ACCEL   = 8'h20;
  localparam logic [ADR_W-1:0] OFS_DECEL   = 8'h24;
  localparam logic [ADR_W-1:0] OFS_SCURVE  = 8'h28;
  localparam logic [ADR_W-1:0] OFS_ZMODE   = 8'h2c;
  localparam logic [ADR_W-1:0] OFS_LOCK    = 8'h30;
  localparam logic [ADR_W-1:0] OFS_OVSPD   = 8'h34;
  localparam logic [ADR_W-1:0] OFS_CTRL    = 8'h38;
  localparam logic [ADR_W-1:0] OFS_STAT    = 8'h3c;
  localparam logic [ADR_W-1:0] REG_STRIDE  = 8'h04;

  // Field positions
  localparam int CTRL_USE_PRESET = 0;            // Preset source select
  localparam int CTRL_RELOAD     = 1;            // Write one to reload
  localparam int STAT_HOLD       = 0;            // Position hold active
  localparam int STAT_ZD         = 1;            // Filtered zero input
  localparam int STAT_CMD_LSB    = 16;           // Shaped command field

  // Reset values
  localparam logic [SPD_W-1:0] RST_LOCK  = 16'h001e;
  localparam logic [SPD_W-1:0] RST_OVSPD = 16'h4e20;
  localparam logic [SPD_W-1:0] RST_ZERO  = 16'h0000;

  // Zero-speed modes
  localparam logic [1:0] ZM_OFF        = 2'h0;
  localparam logic [1:0] ZM_CLAMP      = 2'h1;
  localparam logic [1:0] ZM_CLAMP_LOCK = 2'h2;
  localparam logic [1:0] ZM_LOCK       = 2'h3;

  // Timing
  localparam int CLK_HZ         = 40_000_000;    // Clock rate in Hz
  localparam int MS_PER_S       = 1000;          // Milliseconds per second
  localparam int SCURVE_UNIT_MS = 2;             // S-curve unit in ms
  localparam int SCURVE_DEPTH   = 16;            // Averaging slots
  localparam logic [31:0] RPM_PER_UNIT = 32'h0000_03e8;
  localparam logic signed [SPD_W-1:0] RAMP_STEP = 16'sh0001;

  // Hold state machine
  typedef enum logic [1:0] {
    ST_SPEED = 2'b01,
    ST_HOLD  = 2'b10
  } lock_state_t;

endpackage
